// ---- rtl/dtc_pkg.sv ----
/*
 Shared constants and types of the dual timer/counter block.
 Assumes a single 10 MHz clock and an AXI4-Lite master with 8-bit byte addresses.
*/
package dtc_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned PERIPH_DIV_DEF = 12;
   localparam int unsigned AXI_AW = 8;

   // Byte addresses of the registers, one aligned word each.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_A_LO = 8'h08;
   localparam logic [7:0] ADDR_A_HI = 8'h0C;
   localparam logic [7:0] ADDR_B_LO = 8'h10;
   localparam logic [7:0] ADDR_B_HI = 8'h14;

   // Register indices produced by the address decoder.
   localparam logic [2:0] IDX_CTRL = 3'h0;
   localparam logic [2:0] IDX_MODE = 3'h1;
   localparam logic [2:0] IDX_A_LO = 3'h2;
   localparam logic [2:0] IDX_A_HI = 3'h3;
   localparam logic [2:0] IDX_B_LO = 3'h4;
   localparam logic [2:0] IDX_B_HI = 3'h5;
   localparam logic [2:0] IDX_NONE = 3'h7;

   // Timer control register fields.
   localparam int unsigned TF_B = 7;
   localparam int unsigned TR_B = 6;
   localparam int unsigned TF_A = 5;
   localparam int unsigned TR_A = 4;

   // Timer mode register fields.
   localparam int unsigned GATE_B = 7;
   localparam int unsigned SRC_B = 6;
   localparam int unsigned MB_HI = 5;
   localparam int unsigned MB_LO = 4;
   localparam int unsigned GATE_A = 3;
   localparam int unsigned SRC_A = 2;
   localparam int unsigned MA_HI = 1;
   localparam int unsigned MA_LO = 0;

   // Synchroniser lanes of the pins.
   localparam int unsigned PIN_CNT_A = 0;
   localparam int unsigned PIN_CNT_B = 1;
   localparam int unsigned PIN_GATE_A = 2;
   localparam int unsigned PIN_GATE_B = 3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_13BIT = 2'b00,
      MODE_16BIT = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT = 2'b11
   } dtc_mode_t;

   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [7:0] w_byte;
      logic w_en;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [7:0] ctrl, mode, a_lo, a_hi, b_lo, b_hi;
      logic [3:0] s1, s2, s3;
      logic [7:0] presc;
      logic baud;
   } dtc_state_t;

   // Every register and flag comes out of reset as zero.
   localparam dtc_state_t ST_RESET = '0;
endpackage

// ---- rtl/dtc_timers.sv ----
/*
 Two timer/counters with an AXI4-Lite register slave.
 Assumes pins are asynchronous to aclk and service pulses come from aclk logic.
*/
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
// How it works
// - Timer A reload mode counts its low byte, reloading from high on wrap.
// - Timer A low-byte wrap in reload mode sets timer A overflow flag.
// - Servicing timer A interrupt clears its overflow flag in hardware.
// - Timer A reload never changes its high byte.
// - New high-byte value written any time is used by the next reload.
// - Split mode: timer A low byte is an 8-bit counter with own controls.
// - Split mode high byte counts peripheral ticks, runs on B run, sets B flag.
// - Timer B uses mode register bits 7..4 and control bits 6,7.
// - Timer B counts when run set, and gate pin high if gated.
// - Timer B wrap to zero sets its flag and requests an interrupt, unless timer A is in split mode.
// - Mode 0: five-bit prescaler in low byte carries into high byte.
// - Mode 1: low and high bytes form one 16-bit counter.
// - Mode 2: low byte counts, reloads from high and sets flag on wrap.
// - Timer B reload leaves its high byte untouched.
// - Timer B mode 3 halts and holds the count.
// - Timer B overflow drives the serial baud tick output.
// - Source bit picks peripheral tick or falling edges on count pin.
module dtc_timers #(
   parameter int unsigned PERIPH_DIV = dtc_pkg::PERIPH_DIV_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [dtc_pkg::AXI_AW-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [dtc_pkg::AXI_AW-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic count_a_pin,
   input wire logic count_b_pin,
   input wire logic ext_irq_zero_pin,
   input wire logic ext_irq_one_pin,
   input wire logic irq_service_a,
   input wire logic irq_service_b,
   output logic timer_a_irq,
   output logic timer_b_irq,
   output logic baud_tick
);
   import dtc_pkg::*;

   localparam logic [7:0] PDIV_LAST = 8'(PERIPH_DIV - 1);

   dtc_state_t q;
   dtc_state_t n;
   logic ptick;
   logic [3:0] fall;
   logic tick_a, tick_b, run_a, run_b, inc_a, inc_b, inc_ah;
   dtc_mode_t mode_a, mode_b;
   logic [16:0] st_a, st_b;
   logic [8:0] sum_al, sum_ah;
   logic ovf_a, ovf_ah, ovf_b;
   logic wr;
   logic [2:0] wr_idx;

   function automatic logic [2:0] dec(input logic [7:0] a);
      logic [7:0] w;
      w = {a[7:2], 2'b00};
      case (w)
         ADDR_CTRL: dec = IDX_CTRL;
         ADDR_MODE: dec = IDX_MODE;
         ADDR_A_LO: dec = IDX_A_LO;
         ADDR_A_HI: dec = IDX_A_HI;
         ADDR_B_LO: dec = IDX_B_LO;
         ADDR_B_HI: dec = IDX_B_HI;
         default: dec = IDX_NONE;
      endcase
   endfunction

   // One count step; returns {overflow, high, low}. Mode 3 holds.
   function automatic logic [16:0] step(input dtc_mode_t m, input logic [7:0] lo,
                                        input logic [7:0] hi);
      logic [5:0] p;
      logic [8:0] h;
      logic [8:0] l;
      p = '0;
      h = '0;
      l = '0;
      step = {1'b0, hi, lo};
      case (m)
         MODE_13BIT: begin
            p = {1'b0, lo[4:0]} + 6'h01;
            h = {1'b0, hi} + {8'h00, p[5]};
            step = {h[8], h[7:0], lo[7:5], p[4:0]};
         end
         MODE_16BIT: begin
            step = {1'b0, hi, lo} + 17'h00001;
         end
         MODE_RELOAD: begin
            l = {1'b0, lo} + 9'h001;
            step = l[8] ? {1'b1, hi, hi} : {1'b0, hi, l[7:0]};
         end
         default: begin
            step = {1'b0, hi, lo};
         end
      endcase
   endfunction

   always_comb begin
      n = q;
      // Only the second and third stages feed logic; the first only feeds the second.
      n.s1 = {ext_irq_one_pin, ext_irq_zero_pin, count_b_pin, count_a_pin};
      n.s2 = q.s1;
      n.s3 = q.s2;
      fall = q.s3 & ~q.s2;
      ptick = (q.presc == PDIV_LAST);
      n.presc = ptick ? 8'h00 : 8'(q.presc + 8'h01);

      mode_a = dtc_mode_t'(q.mode[MA_HI:MA_LO]);
      mode_b = dtc_mode_t'(q.mode[MB_HI:MB_LO]);
      tick_a = q.mode[SRC_A] ? fall[PIN_CNT_A] : ptick;
      tick_b = q.mode[SRC_B] ? fall[PIN_CNT_B] : ptick;
      run_a = q.ctrl[TR_A] && (!q.mode[GATE_A] || q.s2[PIN_GATE_A]);
      run_b = q.ctrl[TR_B] && (!q.mode[GATE_B] || q.s2[PIN_GATE_B]);
      inc_a = run_a && tick_a;
      inc_b = run_b && tick_b;
      inc_ah = (mode_a == MODE_SPLIT) && q.ctrl[TR_B] && ptick;

      st_a = step(mode_a, q.a_lo, q.a_hi);
      st_b = step(mode_b, q.b_lo, q.b_hi);
      sum_al = {1'b0, q.a_lo} + 9'h001;
      sum_ah = {1'b0, q.a_hi} + 9'h001;
      ovf_a = 1'b0;
      ovf_ah = 1'b0;
      ovf_b = inc_b && st_b[16];

      if (mode_a == MODE_SPLIT) begin
         if (inc_a) begin
            n.a_lo = sum_al[7:0];
            ovf_a = sum_al[8];
         end
         if (inc_ah) begin
            n.a_hi = sum_ah[7:0];
            ovf_ah = sum_ah[8];
         end
      end else if (inc_a) begin
         n.a_lo = st_a[7:0];
         n.a_hi = st_a[15:8];
         ovf_a = st_a[16];
      end
      if (inc_b) begin
         n.b_lo = st_b[7:0];
         n.b_hi = st_b[15:8];
      end
      n.baud = ovf_b;

      // Flags drop on service before the write and set paths, so a set wins.
      if (irq_service_a) begin
         n.ctrl[TF_A] = 1'b0;
      end
      if (irq_service_b) begin
         n.ctrl[TF_B] = 1'b0;
      end

      // Write path: address and data are taken in either order.
      if (awvalid && awready) begin
         n.aw_got = 1'b1;
         n.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         n.w_got = 1'b1;
         n.w_byte = wdata[7:0];
         n.w_en = wstrb[0];
      end
      wr = q.aw_got && q.w_got && !q.bvalid;
      wr_idx = wr ? dec(q.aw_addr) : IDX_NONE;
      if (wr) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (q.bvalid && bready) begin
         n.bvalid = 1'b0;
      end
      if (q.w_en) begin
         case (wr_idx)
            IDX_CTRL: n.ctrl = q.w_byte;
            IDX_MODE: n.mode = q.w_byte;
            IDX_A_LO: n.a_lo = q.w_byte;
            IDX_A_HI: n.a_hi = q.w_byte;
            IDX_B_LO: n.b_lo = q.w_byte;
            IDX_B_HI: n.b_hi = q.w_byte;
            default: n.ctrl = n.ctrl;
         endcase
      end

      // Hardware set comes last so it beats any clear in the same cycle.
      if (ovf_a) begin
         n.ctrl[TF_A] = 1'b1;
      end
      if ((mode_a == MODE_SPLIT) ? ovf_ah : ovf_b) begin
         n.ctrl[TF_B] = 1'b1;
      end

      // Read path: one read at a time, answered the cycle after acceptance.
      if (arvalid && arready) begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         case (dec(araddr))
            IDX_CTRL: n.rdata = q.ctrl;
            IDX_MODE: n.rdata = q.mode;
            IDX_A_LO: n.rdata = q.a_lo;
            IDX_A_HI: n.rdata = q.a_hi;
            IDX_B_LO: n.rdata = q.b_lo;
            IDX_B_HI: n.rdata = q.b_hi;
            default: begin
               n.rdata = 8'h00;
               n.rresp = RESP_SLVERR;
            end
         endcase
      end else if (q.rvalid && rready) begin
         n.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= ST_RESET;
      end else begin
         q <= n;
      end
   end

   assign awready = !q.aw_got && !q.bvalid;
   assign wready = !q.w_got && !q.bvalid;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = !q.rvalid;
   assign rvalid = q.rvalid;
   assign rdata = {24'h000000, q.rdata};
   assign rresp = q.rresp;
   assign timer_a_irq = q.ctrl[TF_A];
   assign timer_b_irq = q.ctrl[TF_B];
   assign baud_tick = q.baud;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_a_wrap;
      (mode_a == MODE_RELOAD) && inc_a && (q.a_lo == 8'hFF) && (wr_idx == IDX_NONE);
   endsequence

   sequence s_b_wrap;
      (mode_a != MODE_SPLIT) && inc_b && st_b[16];
   endsequence

   property p_reload_a;
      s_a_wrap |=> (q.a_lo == $past(q.a_hi)) && (q.a_hi == $past(q.a_hi));
   endproperty
   a_reload_a: assert property (p_reload_a) else $error("timer A reload wrong");

   property p_new_reload;
      (wr_idx == IDX_A_HI) && q.w_en |=> q.a_hi == $past(q.w_byte);
   endproperty
   a_new_reload: assert property (p_new_reload) else $error("new reload unused");

   property p_flag_a;
      s_a_wrap |=> timer_a_irq;
   endproperty
   a_flag_a: assert property (p_flag_a) else $error("timer A flag not set");

   property p_svc_a;
      irq_service_a && !ovf_a && (wr_idx != IDX_CTRL) |=> !timer_a_irq;
   endproperty
   a_svc_a: assert property (p_svc_a) else $error("service kept flag");

   property p_split_hi;
      inc_ah && (q.a_hi == 8'hFF) && (wr_idx == IDX_NONE) |=> timer_b_irq && (q.a_hi == 8'h00);
   endproperty
   a_split_hi: assert property (p_split_hi) else $error("split high wrong");

   property p_gate_b;
      q.mode[GATE_B] && !q.s2[PIN_GATE_B] && !wr |=> $stable(q.b_lo) && $stable(q.b_hi);
   endproperty
   a_gate_b: assert property (p_gate_b) else $error("timer B counted when gated");

   property p_flag_b;
      s_b_wrap |=> (timer_b_irq && baud_tick) ##1 (!baud_tick || $past(ovf_b));
   endproperty
   a_flag_b: assert property (p_flag_b) else $error("timer B overflow lost");

   property p_halt_b;
      (mode_b == MODE_SPLIT) && !wr |=> $stable(q.b_lo) && $stable(q.b_hi);
   endproperty
   a_halt_b: assert property (p_halt_b) else $error("timer B not halted");

   property p_b13;
      (mode_b == MODE_13BIT) && inc_b && (q.b_lo[4:0] == 5'h1F) && !wr
         |=> (q.b_hi == 8'($past(q.b_hi) + 8'h01)) && (q.b_lo[4:0] == 5'h00);
   endproperty
   a_b13: assert property (p_b13) else $error("prescaler carry wrong");

   property p_keep_hi_b;
      (mode_b == MODE_RELOAD) && ovf_b && !wr |=> (q.b_hi == $past(q.b_hi))
         && (q.b_lo == $past(q.b_hi));
   endproperty
   a_keep_hi_b: assert property (p_keep_hi_b) else $error("reload changed high");
endmodule

// ---- test/dtc_pin_model.sv ----
/*
 Far-side model of the count and gate pins of the timer block.
 Assumes the caller drives its tasks from the bench and that the block synchronises the pins.
*/
`timescale 1ns/1ns
module dtc_pin_model (
   input wire logic aclk,
   output logic count_a_pin,
   output logic count_b_pin,
   output logic ext_irq_zero_pin,
   output logic ext_irq_one_pin
);
   initial begin
      count_a_pin = 1'b1;
      count_b_pin = 1'b1;
      ext_irq_zero_pin = 1'b1;
      ext_irq_one_pin = 1'b1;
   end

   // The low level is held four clocks so the synchroniser cannot miss it, then six high clocks let the count settle.
   task automatic fall(input bit on_b);
      @(posedge aclk);
      if (on_b) count_b_pin <= 1'b0;
      else count_a_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      count_a_pin <= 1'b1;
      count_b_pin <= 1'b1;
      repeat (6) @(posedge aclk);
   endtask

   task automatic gate_b(input logic lvl);
      @(posedge aclk);
      ext_irq_one_pin <= lvl;
   endtask
endmodule

// ---- test/test_dtc_timers.sv ----
/*
 Self-checking bench of the dual timer block, driven over AXI4-Lite.
 Assumes the hand-over timing of the register slave and a prescaler of two clocks.
*/
`timescale 1ns/1ns
module test_dtc_timers;
   import dtc_pkg::*;
   logic aclk = 1'b0, aresetn;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, a_irq, b_irq, baud;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic svc_a, svc_b;
   logic cnt_a, cnt_b, gate_a, gate_b;
   int error_cnt = 0, n_compared = 0, baud_n = 0;

   always #50 aclk = ~aclk;
   always @(posedge aclk) if (baud === 1'b1) baud_n++;

   dtc_pin_model pins_u (.aclk(aclk), .count_a_pin(cnt_a), .count_b_pin(cnt_b),
      .ext_irq_zero_pin(gate_a), .ext_irq_one_pin(gate_b));
   dtc_timers #(.PERIPH_DIV(2)) dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .count_a_pin(cnt_a), .count_b_pin(cnt_b), .ext_irq_zero_pin(gate_a),
      .ext_irq_one_pin(gate_b), .irq_service_a(svc_a), .irq_service_b(svc_b),
      .timer_a_irq(a_irq), .timer_b_irq(b_irq), .baud_tick(baud));

   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: data %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: resp %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
         input logic [3:0] s = 4'hF);
      bit aw_d, w_d, b_d;
      aw_d = 0;
      w_d = 0;
      b_d = 0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= {24'h0, d};
      wstrb <= s;
      bready <= 1'b1;
      while (!b_d) begin
         @(posedge aclk);
         if (!aw_d && awready) begin
            aw_d = 1;
            awvalid <= 1'b0;
         end
         if (!w_d && wready) begin
            w_d = 1;
            wvalid <= 1'b0;
         end
         if (aw_d && w_d && bvalid) begin
            b_d = 1;
            bready <= 1'b0;
            check_resp(bresp, (a > ADDR_B_HI) ? RESP_SLVERR : RESP_OKAY);
         end
      end
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ar_d;
      ar_d = 0;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (!ar_d && arready) begin
            ar_d = 1;
            arvalid <= 1'b0;
         end else if (ar_d && rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      check_resp(r, (a > ADDR_B_HI) ? RESP_SLVERR : RESP_OKAY);
      check_data(d, {24'h0, exp});
   endtask

   // Every preset happens with both timers stopped; a running preset is unpredictable.
   task automatic setup(input logic [7:0] md, input logic [7:0] al, input logic [7:0] ah,
         input logic [7:0] bl, input logic [7:0] bh, input logic [7:0] ct);
      axi_write(ADDR_CTRL, 8'h00);
      axi_write(ADDR_MODE, md);
      axi_write(ADDR_A_LO, al);
      axi_write(ADDR_A_HI, ah);
      axi_write(ADDR_B_LO, bl);
      axi_write(ADDR_B_HI, bh);
      axi_write(ADDR_CTRL, ct);
   endtask

   task automatic service(input bit on_b);
      @(posedge aclk);
      if (on_b) svc_b <= 1'b1;
      else svc_a <= 1'b1;
      @(posedge aclk);
      svc_a <= 1'b0;
      svc_b <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask

   // The tests need well under two thousand clocks, so this span only trips on a hang.
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      wrap_up();
   end

   initial begin
      int b0;
      aresetn <= 1'b0;
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b0;
      arvalid <= 1'b0;
      rready <= 1'b0;
      awaddr <= 8'h00;
      araddr <= 8'h00;
      wdata <= 32'h0;
      wstrb <= 4'h0;
      svc_a <= 1'b0;
      svc_b <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i <= 6; i++) rd_chk(8'(4 * i), 8'h00);
      // A write whose low byte strobe is off is answered but must leave the register alone.
      axi_write(ADDR_B_HI, 8'h5A, 4'h0);
      rd_chk(ADDR_B_HI, 8'h00);
      $display("test reset_map done");
      setup(8'h06, 8'hFD, 8'hFE, 8'h00, 8'h00, 8'h10);
      repeat (3) pins_u.fall(0);
      rd_chk(ADDR_A_LO, 8'hFE);
      rd_chk(ADDR_A_HI, 8'hFE);
      rd_chk(ADDR_CTRL, 8'h30);
      check_data({31'h0, a_irq}, 32'h1);
      axi_write(ADDR_A_HI, 8'h10);
      repeat (2) pins_u.fall(0);
      rd_chk(ADDR_A_LO, 8'h10);
      service(0);
      rd_chk(ADDR_CTRL, 8'h10);
      $display("test timer_a_reload done");
      b0 = baud_n;
      setup(8'h50, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h40);
      rd_chk(ADDR_MODE, 8'h50);
      pins_u.fall(1);
      rd_chk(ADDR_B_LO, 8'h00);
      rd_chk(ADDR_B_HI, 8'h00);
      rd_chk(ADDR_CTRL, 8'hC0);
      check_data({31'h0, b_irq}, 32'h1);
      check_data(32'(baud_n - b0), 32'h1);
      $display("test timer_b_16bit done");
      setup(8'h40, 8'h00, 8'h00, 8'hFF, 8'h05, 8'h40);
      pins_u.fall(1);
      rd_chk(ADDR_B_LO, 8'hE0);
      rd_chk(ADDR_B_HI, 8'h06);
      $display("test timer_b_13bit done");
      setup(8'h60, 8'h00, 8'h00, 8'hFF, 8'h80, 8'h40);
      pins_u.fall(1);
      rd_chk(ADDR_B_LO, 8'h80);
      rd_chk(ADDR_B_HI, 8'h80);
      rd_chk(ADDR_CTRL, 8'hC0);
      $display("test timer_b_reload done");
      setup(8'hD0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40);
      pins_u.gate_b(1'b0);
      pins_u.fall(1);
      rd_chk(ADDR_B_LO, 8'h00);
      pins_u.gate_b(1'b1);
      pins_u.fall(1);
      rd_chk(ADDR_B_LO, 8'h01);
      $display("test timer_b_gate done");
      setup(8'h70, 8'h00, 8'h00, 8'h42, 8'h24, 8'h40);
      pins_u.fall(1);
      rd_chk(ADDR_B_LO, 8'h42);
      rd_chk(ADDR_B_HI, 8'h24);
      $display("test timer_b_halt done");
      setup(8'h77, 8'h33, 8'hFE, 8'h00, 8'h00, 8'h00);
      rd_chk(ADDR_CTRL, 8'h00);
      axi_write(ADDR_CTRL, 8'h40);
      repeat (20) @(posedge aclk);
      rd_chk(ADDR_CTRL, 8'hC0);
      rd_chk(ADDR_A_LO, 8'h33);
      service(1);
      rd_chk(ADDR_CTRL, 8'h40);
      axi_write(ADDR_CTRL, 8'h10);
      pins_u.fall(0);
      rd_chk(ADDR_A_LO, 8'h34);
      $display("test timer_a_split done");
      rd_chk(8'h18, 8'h00);
      wrap_up();
   end
endmodule
